// ===== fvd_map.svh
`ifndef FVD_MAP_SVH
`define FVD_MAP_SVH

// object indices
`define FVD_IX_TPDO1_COMM   16'h1800
`define FVD_IX_TPDO1_MAP    16'h1a00
`define FVD_IX_TPDO2_MAP    16'h1a01
`define FVD_IX_LINK_LOSS    16'h6007
`define FVD_IX_ERROR        16'h603f
`define FVD_IX_COMMAND      16'h6040
`define FVD_IX_STATE        16'h6041
`define FVD_IX_TARGET       16'h6042
`define FVD_IX_DEMAND       16'h6043
`define FVD_IX_ACCEL        16'h604f
`define FVD_IX_SLOWDOWN     16'h6050
`define FVD_IX_FASTSTOP     16'h6051
`define FVD_IX_FS_REACT     16'h605a
`define FVD_IX_MODE         16'h6060
`define FVD_IX_MODE_DISP    16'h6061

// reset values and fixed constants
`define FVD_RST_MAP1_CNT    8'h02
`define FVD_RST_MAP1_E1     32'h60410010
`define FVD_RST_MAP1_E2     32'h60430010
`define FVD_RST_LINK_LOSS   16'h0002
`define FVD_RST_ACCEL       32'h00002710
`define FVD_RST_SLOWDOWN    32'h00002710
`define FVD_RST_FASTSTOP    32'h000003e8
`define FVD_RST_FS_REACT    16'h0002
`define FVD_MODE_VELOCITY   8'h02
`define FVD_RST_SPARE       8'h03
`define FVD_RST_TX_TYPE     8'hff
`define FVD_COMM_COUNT      8'h05
`define FVD_COB_BASE        32'h00000180
`define FVD_MAP_MAX         8'h04

// transmission types
`define FVD_TT_CYC_MAX      8'hf0
`define FVD_TT_ASYNC        8'hff

// command word fields
`define FVD_CW_SO           0
`define FVD_CW_EV           1
`define FVD_CW_QS           2
`define FVD_CW_EO           3
`define FVD_CW_RFG_EN       4
`define FVD_CW_RFG_UNLOCK   5
`define FVD_CW_RFG_REF      6
`define FVD_CW_FAULT_RST    7

// state word fields
`define FVD_SW_RTSO         0
`define FVD_SW_SON          1
`define FVD_SW_OPEN         2
`define FVD_SW_FAULT        3
`define FVD_SW_VOLT         4
`define FVD_SW_QSTOP_N      5
`define FVD_SW_SOD          6
`define FVD_SW_WARN         7
`define FVD_SW_REMOTE       9
`define FVD_SW_TGT_REACHED  10
`define FVD_SW_LIMIT        11

// timing
`define FVD_CLK_HZ          20000000
`define FVD_BASE_TICK_US    100
`define FVD_BASE_CYC        ((`FVD_CLK_HZ / 1000000) * `FVD_BASE_TICK_US)
`define FVD_MS_TICKS        10
`define FVD_COARSE_TICKS    1000
`define FVD_INHIBIT_STEP    10

`endif

// ===== fvd_pkg.sv
package fvd_pkg;

  // one object-dictionary access, addressed to a node
  typedef struct packed {
    logic [6:0]  node;
    logic [15:0] index;
    logic [7:0]  sub;
    logic        wr;
    logic        rd;
    logic [31:0] wdata;
  } fvd_od_req_t;

  typedef struct packed {
    logic        ack;
    logic        err;
    logic [31:0] rdata;
  } fvd_od_rsp_t;

  // one process-data frame: four 16-bit slots and a byte count
  typedef struct packed {
    logic        valid;
    logic [3:0]  len;
    logic [63:0] data;
  } fvd_pdo_t;

  typedef enum logic [6:0] {
    FVD_ST_NOT_READY = 7'h01,
    FVD_ST_SW_ON_DIS = 7'h02,
    FVD_ST_READY     = 7'h04,
    FVD_ST_SWITCHED  = 7'h08,
    FVD_ST_OP_EN     = 7'h10,
    FVD_ST_QSTOP     = 7'h20,
    FVD_ST_FAULT     = 7'h40
  } fvd_state_t;

endpackage

// ===== fvd_drive.sv
`include "fvd_map.svh"

module fvd_drive
  import fvd_pkg::*;
#(
  parameter int          MAX_RPM     = 1500,
  parameter logic [15:0] ERROR_CODE  = 16'h1000 // arbitrary fault code
) (
  input  wire logic        sys_clk_i,
  input  wire logic        rstn_i,
  input  wire fvd_od_req_t od_req_i,
  output fvd_od_rsp_t      od_rsp_o,
  input  wire logic [6:0]  node_address_setting_i,
  input  wire logic        time_resolution_setting_i,
  input  wire logic        sync_i,
  input  wire logic        link_lost_i,
  input  wire logic        fault_i,
  input  wire logic        warning_i,
  input  wire logic        remote_i,
  output fvd_pdo_t         tpdo1_o,
  output logic             power_enable_o,
  output logic [15:0]      speed_cmd_o
);

  if (MAX_RPM < 1 || MAX_RPM > 32767) begin : g_bad_rpm
    $error("MAX_RPM out of range");
  end

  localparam logic [32:0] RPM_STEP = 33'(MAX_RPM);
  localparam logic [11:0] BASE_CYC = 12'(`FVD_BASE_CYC);

  // object store
  logic [7:0]  map_cnt_reg [2];
  logic [31:0] map_reg     [2][4];
  logic [15:0] link_loss_reg, error_reg, command_reg, target_reg, demand_reg, fs_react_reg;
  logic [31:0] accel_reg, slowdown_reg, faststop_reg;
  logic [7:0]  tx_type_reg;
  logic [15:0] inhibit_reg, event_reg;
  fvd_state_t  state_reg, state_next;
  fvd_od_rsp_t rsp_reg;
  fvd_pdo_t    pdo_reg;

  // access decode: a request counts only at our own, valid node address
  wire node_ok   = (node_address_setting_i != 7'h00) &&
                   (od_req_i.node == node_address_setting_i);
  wire acc_wr    = node_ok & od_req_i.wr;
  wire acc_rd    = node_ok & od_req_i.rd & ~od_req_i.wr;
  wire [15:0] ix = od_req_i.index;
  wire [7:0]  sb = od_req_i.sub;
  wire [31:0] wd = od_req_i.wdata;
  wire sub0      = (sb == 8'h00);
  wire is_map1   = (ix == `FVD_IX_TPDO1_MAP);
  wire is_map2   = (ix == `FVD_IX_TPDO2_MAP);
  wire map_sel   = is_map2;
  wire map_hit   = (is_map1 | is_map2) && (sb <= `FVD_MAP_MAX);
  wire is_comm   = (ix == `FVD_IX_TPDO1_COMM) && (sb <= `FVD_COMM_COUNT);
  wire is_ramp   = (ix == `FVD_IX_ACCEL) | (ix == `FVD_IX_SLOWDOWN) | (ix == `FVD_IX_FASTSTOP);

  // write checks: ramp zero refused in coarse units, inhibit must be a multiple of ten
  wire ramp_bad  = is_ramp & sub0 & time_resolution_setting_i & (wd == 32'h0);
  wire inh_bad   = is_comm & (sb == 8'h03) &
                   ((wd[15:0] % 16'(`FVD_INHIBIT_STEP)) != 16'h0);
  wire cnt_bad   = map_hit & sub0 & (wd[7:0] > `FVD_MAP_MAX);
  wire rw_obj    = map_hit | (is_comm & (sb >= 8'h02)) |
                   (sub0 & (is_ramp | ix == `FVD_IX_LINK_LOSS | ix == `FVD_IX_COMMAND |
                            ix == `FVD_IX_TARGET | ix == `FVD_IX_FS_REACT));
  wire wr_ok     = acc_wr & rw_obj & ~ramp_bad & ~inh_bad & ~cnt_bad;
  wire cw_wr     = wr_ok & (ix == `FVD_IX_COMMAND);

  // command word decode
  wire [15:0] cw      = command_reg;
  wire cmd_dis_v      = ~cw[`FVD_CW_EV];
  wire cmd_qstop      = cw[`FVD_CW_EV] & ~cw[`FVD_CW_QS];
  wire cmd_shutdown   = cw[`FVD_CW_EV] & cw[`FVD_CW_QS] & ~cw[`FVD_CW_SO];
  wire cmd_switch_on  = cw[`FVD_CW_EV] & cw[`FVD_CW_QS] & cw[`FVD_CW_SO] & ~cw[`FVD_CW_EO];
  wire cmd_enable     = cw[`FVD_CW_EV] & cw[`FVD_CW_QS] & cw[`FVD_CW_SO] & cw[`FVD_CW_EO];
  logic fault_rst_prev;
  wire fault_rst_rise = cw[`FVD_CW_FAULT_RST] & ~fault_rst_prev;

  // link loss and quick-stop option decode
  logic link_prev;
  wire link_evt    = link_lost_i & ~link_prev;
  wire link_volt   = link_evt & (link_loss_reg == 16'h0002);
  wire link_qs     = link_evt & (link_loss_reg == 16'h0003);
  wire qs_disable  = (fs_react_reg == 16'h0000);
  wire qs_fast     = (fs_react_reg == 16'h0002) | (fs_react_reg == 16'h0006);
  wire qs_hold     = (fs_react_reg == 16'h0005) | (fs_react_reg == 16'h0006);
  wire powered     = (state_reg == FVD_ST_READY) | (state_reg == FVD_ST_SWITCHED) |
                     (state_reg == FVD_ST_OP_EN) | (state_reg == FVD_ST_QSTOP);

  // ramp goal and limit
  wire signed [15:0] tgt_s   = target_reg;
  wire signed [15:0] dem_s   = demand_reg;
  wire signed [15:0] max_s   = 16'(MAX_RPM);
  wire signed [15:0] tgt_lim = (tgt_s > max_s) ? max_s : (tgt_s < -max_s) ? -max_s : tgt_s;
  wire over_limit            = (tgt_s != tgt_lim);
  wire in_op                 = (state_reg == FVD_ST_OP_EN);
  wire rfg_zero              = ~(in_op | (state_reg == FVD_ST_QSTOP)) |
                               (in_op & ~cw[`FVD_CW_RFG_EN]) |
                               ((state_reg == FVD_ST_QSTOP) & qs_disable);
  wire rfg_hold              = in_op & ~cw[`FVD_CW_RFG_UNLOCK];
  wire signed [15:0] goal    = (in_op & cw[`FVD_CW_RFG_REF]) ? tgt_lim : 16'sh0;
  wire toward_zero           = (dem_s > 0 && goal < dem_s) || (dem_s < 0 && goal > dem_s);
  wire [31:0] ramp_t         = (state_reg == FVD_ST_QSTOP) ?
                               (qs_fast ? faststop_reg : slowdown_reg) :
                               (toward_zero ? slowdown_reg : accel_reg);
  wire at_goal               = (dem_s == goal);

  // time base: 100us ticks, then 1ms or 100ms ramp units
  logic [11:0] base_cnt;
  logic [9:0]  unit_cnt;
  logic [3:0]  ms_cnt;
  wire base_tick  = (base_cnt == BASE_CYC - 12'h1);
  wire [9:0] unit_max = time_resolution_setting_i ? 10'(`FVD_COARSE_TICKS - 1) :
                                                    10'(`FVD_MS_TICKS - 1);
  wire unit_tick  = base_tick & (unit_cnt >= unit_max);
  wire ms_tick    = base_tick & (ms_cnt == 4'(`FVD_MS_TICKS - 1));

  // accumulator: full-scale speed change takes one ramp time
  logic [32:0] acc_reg;
  wire [32:0] acc_add  = (unit_tick & ~at_goal) ? acc_reg + RPM_STEP : acc_reg;
  wire step_now        = ~at_goal & ~rfg_hold & ({1'b0, ramp_t} <= acc_add);
  wire [32:0] acc_next = at_goal ? 33'h0 : step_now ? acc_add - {1'b0, ramp_t} : acc_add;
  wire signed [15:0] dem_step = (ramp_t == 32'h0) ? goal :
                                (goal > dem_s) ? dem_s + 16'sh1 : dem_s - 16'sh1;
  wire [15:0] demand_next = rfg_zero ? 16'h0 : step_now ? dem_step : demand_reg;

  // drive state machine
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      FVD_ST_NOT_READY: state_next = FVD_ST_SW_ON_DIS;
      FVD_ST_SW_ON_DIS: if (cmd_shutdown) state_next = FVD_ST_READY;
      FVD_ST_READY: begin
        if (cmd_dis_v | cmd_qstop) state_next = FVD_ST_SW_ON_DIS;
        else if (cmd_switch_on) state_next = FVD_ST_SWITCHED;
        else if (cmd_enable) state_next = FVD_ST_OP_EN;
      end
      FVD_ST_SWITCHED: begin
        if (cmd_dis_v | cmd_qstop) state_next = FVD_ST_SW_ON_DIS;
        else if (cmd_shutdown) state_next = FVD_ST_READY;
        else if (cmd_enable) state_next = FVD_ST_OP_EN;
      end
      FVD_ST_OP_EN: begin
        if (cmd_dis_v) state_next = FVD_ST_SW_ON_DIS;
        else if (cmd_qstop) state_next = qs_disable ? FVD_ST_SW_ON_DIS : FVD_ST_QSTOP;
        else if (cmd_shutdown) state_next = FVD_ST_READY;
        else if (cmd_switch_on) state_next = FVD_ST_SWITCHED;
      end
      FVD_ST_QSTOP: begin
        if (cmd_dis_v | qs_disable) state_next = FVD_ST_SW_ON_DIS;
        else if (qs_hold & cw_wr & (wd[3:0] == 4'hf)) state_next = FVD_ST_OP_EN;
        else if (~qs_hold & (demand_reg == 16'h0)) state_next = FVD_ST_SW_ON_DIS;
      end
      FVD_ST_FAULT: if (fault_rst_rise & ~fault_i) state_next = FVD_ST_SW_ON_DIS;
      default: state_next = FVD_ST_NOT_READY;
    endcase
    // overrides: fault first, then the link-loss reaction
    if (fault_i) state_next = FVD_ST_FAULT;
    else if (link_volt & powered) state_next = FVD_ST_SW_ON_DIS;
    else if (link_qs & in_op) state_next = qs_disable ? FVD_ST_SW_ON_DIS : FVD_ST_QSTOP;
  end

  // state word image of the current state
  wire [15:0] sw_now = {4'h0,
                        over_limit,
                        at_goal & ~rfg_zero,
                        remote_i,
                        1'b0,
                        warning_i,
                        state_reg == FVD_ST_SW_ON_DIS,
                        state_reg != FVD_ST_QSTOP,
                        powered,
                        state_reg == FVD_ST_FAULT,
                        in_op | (state_reg == FVD_ST_QSTOP),
                        in_op | (state_reg == FVD_ST_SWITCHED) | (state_reg == FVD_ST_QSTOP),
                        powered};

  // object values for process-data mapping
  function automatic logic [15:0] fvd_obj16(input logic [15:0] idx);
    case (idx)
      `FVD_IX_STATE:     fvd_obj16 = sw_now;
      `FVD_IX_DEMAND:    fvd_obj16 = demand_reg;
      `FVD_IX_COMMAND:   fvd_obj16 = command_reg;
      `FVD_IX_TARGET:    fvd_obj16 = target_reg;
      `FVD_IX_ERROR:     fvd_obj16 = error_reg;
      `FVD_IX_LINK_LOSS: fvd_obj16 = link_loss_reg;
      `FVD_IX_FS_REACT:  fvd_obj16 = fs_react_reg;
      default:           fvd_obj16 = 16'h0;
    endcase
  endfunction

  // pack the mapped slots of the first transmit object
  wire [63:0] pdo_data;
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_slot
      logic [15:0] slot;
      // always_comb follows what the function reads; a plain assign would go stale
      always_comb begin
        slot = (map_cnt_reg[0] > 8'(g)) ? fvd_obj16(map_reg[0][g][31:16]) : 16'h0;
      end
      assign pdo_data[16*g +: 16] = slot;
    end
  endgenerate

  // transmit triggering
  logic [7:0]  sync_cnt;
  logic [15:0] inhibit_cnt, event_cnt;
  logic [63:0] last_sent;
  logic        pending;
  wire tt_acyc   = (tx_type_reg == 8'h00);
  wire tt_cyc    = (tx_type_reg != 8'h00) && (tx_type_reg <= `FVD_TT_CYC_MAX);
  wire tt_async  = (tx_type_reg == `FVD_TT_ASYNC);
  wire changed   = (pdo_data != last_sent);
  wire cyc_due   = sync_i & tt_cyc & (sync_cnt + 8'h1 >= tx_type_reg);
  wire acyc_due  = sync_i & tt_acyc & changed;
  wire event_due = tt_async & (event_reg != 16'h0) & ms_tick & (event_cnt + 16'h1 >= event_reg);
  wire async_due = tt_async & changed;
  wire want_tx   = (pending | cyc_due | acyc_due | async_due | event_due) &
                   (map_cnt_reg[0] != 8'h0);
  wire send_now  = want_tx & (inhibit_cnt == 16'h0);

  // read-back multiplexer
  logic [31:0] rd_val;
  logic        rd_hit;
  always_comb begin
    rd_val = 32'h0;
    rd_hit = sub0;
    if (map_hit) begin
      rd_hit = 1'b1;
      rd_val = sub0 ? {24'h0, map_cnt_reg[map_sel]} : map_reg[map_sel][sb[1:0] - 2'h1];
    end else if (is_comm) begin
      rd_hit = 1'b1;
      case (sb)
        8'h00:   rd_val = {24'h0, `FVD_COMM_COUNT};
        8'h01:   rd_val = `FVD_COB_BASE + {25'h0, node_address_setting_i};
        8'h02:   rd_val = {24'h0, tx_type_reg};
        8'h03:   rd_val = {16'h0, inhibit_reg};
        8'h04:   rd_val = {24'h0, `FVD_RST_SPARE};
        default: rd_val = {16'h0, event_reg};
      endcase
    end else begin
      case (ix)
        `FVD_IX_ACCEL:     rd_val = accel_reg;
        `FVD_IX_SLOWDOWN:  rd_val = slowdown_reg;
        `FVD_IX_FASTSTOP:  rd_val = faststop_reg;
        `FVD_IX_STATE:     rd_val = {16'h0, sw_now};
        `FVD_IX_MODE,
        `FVD_IX_MODE_DISP: rd_val = {24'h0, `FVD_MODE_VELOCITY};
        default: begin
          rd_val = {16'h0, fvd_obj16(ix)};
          rd_hit = sub0 & ((ix == `FVD_IX_DEMAND) | (ix == `FVD_IX_ERROR) | rw_obj);
        end
      endcase
    end
  end

  // access answer: one cycle after the request, writes refused show err
  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      rsp_reg <= '0;
    end else begin
      rsp_reg.ack   <= acc_wr | acc_rd;
      rsp_reg.err   <= (acc_wr & ~wr_ok) | (acc_rd & ~rd_hit);
      rsp_reg.rdata <= (acc_rd & rd_hit) ? rd_val : 32'h0;
    end
  end

  // mapping objects
  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      map_cnt_reg[0] <= `FVD_RST_MAP1_CNT;
      map_cnt_reg[1] <= 8'h00;
      for (int i = 0; i < 4; i++) begin
        map_reg[0][i] <= (i == 0) ? `FVD_RST_MAP1_E1 : (i == 1) ? `FVD_RST_MAP1_E2 : 32'h0;
        map_reg[1][i] <= 32'h0;
      end
    end else if (wr_ok & map_hit) begin
      if (sub0) map_cnt_reg[map_sel] <= wd[7:0];
      else map_reg[map_sel][sb[1:0] - 2'h1] <= wd;
    end
  end

  // parameter objects written by the master
  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      link_loss_reg <= `FVD_RST_LINK_LOSS;
      command_reg   <= 16'h0;
      target_reg    <= 16'h0;
      accel_reg     <= `FVD_RST_ACCEL;
      slowdown_reg  <= `FVD_RST_SLOWDOWN;
      faststop_reg  <= `FVD_RST_FASTSTOP;
      fs_react_reg  <= `FVD_RST_FS_REACT;
      tx_type_reg   <= `FVD_RST_TX_TYPE;
      inhibit_reg   <= 16'h0;
      event_reg     <= 16'h0;
    end else if (wr_ok & ~map_hit) begin
      if (is_comm && sb == 8'h02) tx_type_reg <= wd[7:0];
      if (is_comm && sb == 8'h03) inhibit_reg <= wd[15:0];
      if (is_comm && sb == 8'h05) event_reg <= wd[15:0];
      if (!is_comm) begin
        case (ix)
          `FVD_IX_LINK_LOSS: link_loss_reg <= wd[15:0];
          `FVD_IX_COMMAND:   command_reg <= wd[15:0];
          `FVD_IX_TARGET:    target_reg <= wd[15:0];
          `FVD_IX_ACCEL:     accel_reg <= wd;
          `FVD_IX_SLOWDOWN:  slowdown_reg <= wd;
          `FVD_IX_FASTSTOP:  faststop_reg <= wd;
          `FVD_IX_FS_REACT:  fs_react_reg <= wd[15:0];
          default:           fs_react_reg <= fs_react_reg;
        endcase
      end
    end
  end

  // drive state, error code and ramp
  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      state_reg      <= FVD_ST_NOT_READY;
      error_reg      <= 16'h0;
      demand_reg     <= 16'h0;
      acc_reg        <= 33'h0;
      fault_rst_prev <= 1'b0;
      link_prev      <= 1'b0;
    end else begin
      state_reg      <= state_next;
      demand_reg     <= demand_next;
      acc_reg        <= rfg_zero ? 33'h0 : acc_next;
      fault_rst_prev <= cw[`FVD_CW_FAULT_RST];
      link_prev      <= link_lost_i;
      if (fault_i) error_reg <= ERROR_CODE;
      else if (state_reg == FVD_ST_FAULT && state_next != FVD_ST_FAULT) error_reg <= 16'h0;
    end
  end

  // time base counters
  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      base_cnt <= 12'h0;
      unit_cnt <= 10'h0;
      ms_cnt   <= 4'h0;
    end else begin
      base_cnt <= base_tick ? 12'h0 : base_cnt + 12'h1;
      if (base_tick) unit_cnt <= (unit_cnt >= unit_max) ? 10'h0 : unit_cnt + 10'h1;
      if (base_tick) ms_cnt <= ms_tick ? 4'h0 : ms_cnt + 4'h1;
    end
  end

  // transmit scheduling; the inhibit window holds back, never drops, a request
  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      sync_cnt    <= 8'h0;
      inhibit_cnt <= 16'h0;
      event_cnt   <= 16'h0;
      last_sent   <= 64'h0;
      pending     <= 1'b0;
      pdo_reg     <= '0;
    end else begin
      if (sync_i & tt_cyc) sync_cnt <= cyc_due ? 8'h0 : sync_cnt + 8'h1;
      if (ms_tick) event_cnt <= event_due ? 16'h0 : event_cnt + 16'h1;
      if (send_now) inhibit_cnt <= inhibit_reg;
      else if (base_tick && inhibit_cnt != 16'h0) inhibit_cnt <= inhibit_cnt - 16'h1;
      pending       <= want_tx & ~send_now;
      pdo_reg.valid <= send_now;
      if (send_now) begin
        pdo_reg.data <= pdo_data;
        pdo_reg.len  <= {map_cnt_reg[0][2:0], 1'b0};
        last_sent    <= pdo_data;
      end
    end
  end

  // drive-side outputs
  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      power_enable_o <= 1'b0;
      speed_cmd_o    <= 16'h0;
    end else begin
      power_enable_o <= in_op | (state_reg == FVD_ST_QSTOP);
      speed_cmd_o    <= demand_reg;
    end
  end

  assign od_rsp_o = rsp_reg;
  assign tpdo1_o  = pdo_reg;

endmodule

// ===== fvd_drive_checker.sv
module fvd_drive_checker
  import fvd_pkg::*;
(
  input wire logic        sys_clk_i,
  input wire logic        rstn_i,
  input wire fvd_od_req_t od_req_i,
  input wire fvd_od_rsp_t od_rsp_o,
  input wire logic [6:0]  node_address_setting_i,
  input wire logic        time_resolution_setting_i,
  input wire logic        fault_i,
  input wire logic        warning_i,
  input wire logic        remote_i,
  input wire logic        power_enable_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rstn_i);
  // request decode shared by the properties; write wins over read
  wire        any_q = od_req_i.wr | od_req_i.rd;
  wire        hit   = any_q && node_address_setting_i != 7'h00
                      && od_req_i.node == node_address_setting_i;
  wire        w_hit = hit && od_req_i.wr;
  wire        r_hit = hit && !od_req_i.wr;
  wire [15:0] ix    = od_req_i.index;
  wire        st_rd = r_hit && ix == 16'h6041;
  wire        md_ix = ix == 16'h6060 || ix == 16'h6061;

  a_ack_next_cycle: assert property (hit |=> od_rsp_o.ack)
    else $error("addressed request got no answer");
  a_foreign_quiet: assert property (any_q && !hit |=> !od_rsp_o.ack)
    else $error("request for another node answered");
  a_mode_locked: assert property (w_hit && md_ix |=> od_rsp_o.err)
    else $error("mode object accepted a write");
  a_mode_value: assert property (
    r_hit && md_ix && od_req_i.sub == 8'h00 |=> od_rsp_o.rdata == 32'h2 && !od_rsp_o.err)
    else $error("mode object not velocity");
  a_state_locked: assert property (w_hit && ix == 16'h6041 |=> od_rsp_o.err)
    else $error("state word accepted a write");
  a_ramp_nonzero: assert property (
    w_hit && time_resolution_setting_i && od_req_i.wdata == 32'h0
    && ix inside {16'h604f, 16'h6050, 16'h6051} |=> od_rsp_o.err)
    else $error("zero ramp accepted in coarse unit");
  a_inhibit_tens: assert property (
    w_hit && ix == 16'h1800 && od_req_i.sub == 8'h03 && od_req_i.wdata[15:0] % 10 != 0
    |=> od_rsp_o.err)
    else $error("inhibit time not a multiple of ten accepted");
  a_fault_bit: assert property (fault_i [*4] ##0 st_rd |=> od_rsp_o.rdata[3])
    else $error("fault not reported in state word");
  a_live_bits: assert property (
    st_rd && $stable(warning_i) && $stable(remote_i)
    |=> od_rsp_o.rdata[7] == $past(warning_i) && od_rsp_o.rdata[9] == $past(remote_i))
    else $error("warning or remote bit wrong");
  a_fault_power: assert property (fault_i [*4] |-> !power_enable_o)
    else $error("power kept on in fault");
endmodule

bind fvd_drive fvd_drive_checker u_chk (
  .sys_clk_i                 (sys_clk_i),
  .rstn_i                    (rstn_i),
  .od_req_i                  (od_req_i),
  .od_rsp_o                  (od_rsp_o),
  .node_address_setting_i    (node_address_setting_i),
  .time_resolution_setting_i (time_resolution_setting_i),
  .fault_i                   (fault_i),
  .warning_i                 (warning_i),
  .remote_i                  (remote_i),
  .power_enable_o            (power_enable_o)
);

// ===== fvd_master.sv
module fvd_master
  import fvd_pkg::*;
(
  input  wire logic        sys_clk_i,
  input  wire fvd_od_rsp_t od_rsp_i,
  output fvd_od_req_t      od_req_o
);
  timeunit 1ns;
  timeprecision 100ps;
  // idle bus at time zero
  initial od_req_o = '0;
  // strobe lives for the taking edge only; fields stay until the answer is read
  task automatic xfer(input logic [6:0] nd, input logic [15:0] ix, input logic [7:0] sb,
                      input logic w, input logic [31:0] d, output fvd_od_rsp_t rsp);
    int n;
    @(posedge sys_clk_i) #1;
    od_req_o = '{nd, ix, sb, w, !w, d};
    @(posedge sys_clk_i) #1;
    od_req_o.wr = 1'b0;
    od_req_o.rd = 1'b0;
    for (n = 0; n < 4 && od_rsp_i.ack !== 1'b1; n++) @(posedge sys_clk_i) #1;
    rsp = od_rsp_i;
    // stale data would hide a decoder that ignores the strobe
    od_req_o.wdata = ~od_req_o.wdata;
  endtask
endmodule

// ===== tb_fieldbus_velocity_drive_objects.sv
module tb_fieldbus_velocity_drive_objects import fvd_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  logic        sys_clk_i = 1'b0;
  logic        rstn_i    = 1'b0;
  logic        res_i     = 1'b0;
  logic        sync_i    = 1'b0;
  logic        lost_i    = 1'b0;
  logic        fault_i   = 1'b0;
  logic        warn_i    = 1'b0;
  logic        remote_i  = 1'b0;
  logic [6:0]  node      = 7'h05;
  fvd_od_req_t od_req;
  fvd_od_rsp_t od_rsp;
  fvd_od_rsp_t rsp;
  fvd_pdo_t    tpdo;
  logic        power;
  logic [15:0] speed;
  int          num_errors  = 0;
  int          comparisons = 0;
  // 20 mhz clock
  initial forever #25 sys_clk_i = ~sys_clk_i;
  fvd_master u_master (.sys_clk_i(sys_clk_i), .od_rsp_i(od_rsp), .od_req_o(od_req));
  fvd_drive u_dut (
    .sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .od_req_i(od_req), .od_rsp_o(od_rsp),
    .node_address_setting_i(node), .time_resolution_setting_i(res_i), .sync_i(sync_i),
    .link_lost_i(lost_i), .fault_i(fault_i), .warning_i(warn_i), .remote_i(remote_i),
    .tpdo1_o(tpdo), .power_enable_o(power), .speed_cmd_o(speed));
  // comparison, verdict and access helpers
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict();
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic acc(input logic [15:0] ix, input logic [7:0] sb, input logic w,
                     input logic [31:0] d);
    u_master.xfer(node, ix, sb, w, d, rsp);
    if (rsp.ack !== 1'b1) begin
      num_errors++;
      print_verdict();
    end
  endtask
  task automatic wr(input logic [15:0] ix, input logic [7:0] sb, input logic [31:0] d,
                    input logic e);
    acc(ix, sb, 1'b1, d);
    check(rsp.err, e);
  endtask
  task automatic rd(input logic [15:0] ix, input logic [7:0] sb, input logic [31:0] e);
    acc(ix, sb, 1'b0, 32'h0);
    check(rsp.rdata, e);
    check(rsp.err, 1'b0);
  endtask
  task automatic sw(input logic [15:0] m, input logic [15:0] e);
    acc(16'h6041, 8'h00, 1'b0, 32'h0);
    check(rsp.rdata & m, e);
  endtask
  // index, sub and value after reset
  localparam logic [55:0] RST_TBL [16] = '{
    56'h1a00_00_00000002, 56'h1a00_01_60410010, 56'h1a00_02_60430010,
    56'h1a00_04_00000000, 56'h1a01_00_00000000, 56'h1800_03_00000000,
    56'h1800_04_00000003, 56'h6007_00_00000002, 56'h603f_00_00000000,
    56'h6040_00_00000000, 56'h6042_00_00000000, 56'h604f_00_00002710,
    56'h6050_00_00002710, 56'h6051_00_000003e8, 56'h605a_00_00000002,
    56'h6061_00_00000002};
  task automatic t_reset_values();
    foreach (RST_TBL[i]) begin
      rd(RST_TBL[i][55:40], RST_TBL[i][39:32], RST_TBL[i][31:0]);
    end
  endtask
  // refused writes leave the stored value alone
  task automatic t_refusals();
    wr(16'h6060, 8'h00, 32'h3, 1'b1);
    rd(16'h6060, 8'h00, 32'h2);
    wr(16'h6041, 8'h00, 32'h7, 1'b1);
    acc(16'h7000, 8'h00, 1'b0, 32'h0);
    check(rsp.err, 1'b1);
    wr(16'h1800, 8'h03, 32'd15, 1'b1);
    wr(16'h1800, 8'h03, 32'd20, 1'b0);
    rd(16'h1800, 8'h03, 32'd20);
    wr(16'h1800, 8'h03, 32'd0, 1'b0);
    res_i = 1'b1;
    wr(16'h604f, 8'h00, 32'h0, 1'b1);
    wr(16'h6051, 8'h00, 32'h0, 1'b1);
    rd(16'h604f, 8'h00, 32'h2710);
    res_i = 1'b0;
    wr(16'h6050, 8'h00, 32'h0, 1'b0);
    wr(16'h6050, 8'h00, 32'h2710, 1'b0);
    wr(16'h1a00, 8'h00, 32'h5, 1'b1);
    u_master.xfer(node + 7'h01, 16'h6041, 8'h00, 1'b0, 32'h0, rsp);
    check(rsp.ack, 1'b0);
  endtask
  // cyclic type 1: one frame per sync carrying state word and demand
  task automatic t_tpdo();
    logic [15:0] s;
    int          n;
    wr(16'h1800, 8'h02, 32'h1, 1'b0);
    acc(16'h6041, 8'h00, 1'b0, 32'h0);
    s = rsp.rdata[15:0];
    sync_i = 1'b1;
    @(posedge sys_clk_i) #1;
    sync_i = 1'b0;
    for (n = 0; n < 8 && tpdo.valid !== 1'b1; n++) @(posedge sys_clk_i) #1;
    check(tpdo.valid, 1'b1);
    check(tpdo.len, 4'h4);
    check(tpdo.data[31:0], {16'h0000, s});
    wr(16'h1800, 8'h02, 32'hff, 1'b0);
  endtask
  // profile walk, held quick stop, live bits, fault and its reset
  task automatic t_states();
    sw(16'h004f, 16'h0040);
    wr(16'h6040, 8'h00, 32'h6, 1'b0);
    sw(16'h004f, 16'h0001);
    wr(16'h6040, 8'h00, 32'h7, 1'b0);
    sw(16'h004f, 16'h0003);
    wr(16'h6040, 8'h00, 32'hf, 1'b0);
    sw(16'h004f, 16'h0007);
    wr(16'h604f, 8'h00, 32'h0, 1'b0);
    wr(16'h6042, 8'h00, 32'h64, 1'b0);
    wr(16'h6040, 8'h00, 32'h7f, 1'b0);
    sw(16'h0400, 16'h0400);
    check(speed, 32'h64);
    wr(16'h605a, 8'h00, 32'h5, 1'b0);
    wr(16'h6040, 8'h00, 32'hb, 1'b0);
    sw(16'h006f, 16'h0007);
    check(power, 1'b1);
    warn_i = 1'b1;
    remote_i = 1'b1;
    sw(16'h0280, 16'h0280);
    fault_i = 1'b1;
    sw(16'h004f, 16'h0008);
    sw(16'h004f, 16'h0008);
    check(power, 1'b0);
    fault_i = 1'b0;
    warn_i = 1'b0;
    remote_i = 1'b0;
    wr(16'h6040, 8'h00, 32'h80, 1'b0);
    sw(16'h004f, 16'h0040);
  endtask
  // bus loss while running: code 2 drops voltage, code 0 leaves it
  task automatic t_link_loss(input logic [15:0] code, input logic exp, input logic [15:0] st);
    int n;
    wr(16'h6007, 8'h00, {16'h0000, code}, 1'b0);
    wr(16'h6040, 8'h00, 32'h6, 1'b0);
    wr(16'h6040, 8'h00, 32'h7, 1'b0);
    wr(16'h6040, 8'h00, 32'hf, 1'b0);
    sw(16'h004f, 16'h0007);
    check(power, 1'b1);
    lost_i = 1'b1;
    for (n = 0; n < 8 && power !== 1'b0; n++) @(posedge sys_clk_i) #1;
    check(power, exp);
    sw(16'h006f, st);
    lost_i = 1'b0;
  endtask
  // main sequence
  initial begin
    repeat (8) @(posedge sys_clk_i);
    #1 rstn_i = 1'b1;
    t_reset_values();
    t_refusals();
    t_tpdo();
    t_states();
    t_link_loss(16'h0002, 1'b0, 16'h0060);
    t_link_loss(16'h0000, 1'b1, 16'h0027);
    t_link_loss(16'h0003, 1'b1, 16'h0007);
    print_verdict();
  end
endmodule
